// *** byte_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; the read data show the oldest entry while valid.
`timescale 1ns/1ps
module byte_fifo
  import lcd_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic      [WIDTH-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign wr_ready = count_q != (AW+1)'(DEPTH);
  assign rd_valid = count_q != '0;
  assign rd_data  = mem_q[rd_ptr_q];
  assign push     = wr_valid && wr_ready;
  assign pop      = rd_valid && rd_ready;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_q[wr_ptr_q] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= AW'(wr_ptr_q + 1'b1);
      end
      if (pop)
      begin
        rd_ptr_q <= AW'(rd_ptr_q + 1'b1);
      end
      count_q <= (AW+1)'(count_q + push - pop);
    end
  end
endmodule

// *** char_lcd_command_interpreter.sv ***
// Command interpreter of a character display controller board.
// Assumes the panel driver consumes one-cycle operation pulses and reads
// glyph patterns through the glyph read port.
`timescale 1ns/1ps
module char_lcd_command_interpreter
  import lcd_pkg::*;
#(
  parameter int CLEAR_WAIT = CLEAR_CYCLES
)
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       rx_ttl,
  input  wire logic       rx_hv,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic [2:0] dip_sw,
  output logic            disp_valid,
  output op_t             disp_op,
  output logic      [7:0] disp_data,
  output logic      [4:0] disp_col,
  output logic      [1:0] disp_row,
  output logic            cursor_on,
  output logic            backlight_on,
  output logic            busy,
  input  wire logic [5:0] glyph_rd_addr,
  output logic      [7:0] glyph_rd_data
);
  typedef enum logic [1:0]
  {
    P_IDLE = 2'b00,
    P_ESC  = 2'b01,
    P_ARGS = 2'b10
  } parse_t;

  typedef enum logic [1:0]
  {
    I_IDLE = 2'b00,
    I_ADDR = 2'b01,
    I_DATA = 2'b10,
    I_ACK  = 2'b11
  } link_t;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [6:0] meta_q;
  logic [6:0] sync_q;
  logic       rx_ttl_s;
  logic       rx_hv_s;
  logic       scl_s;
  logic       sda_s;
  logic [2:0] dip_s;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_q <= 7'h0f;
      sync_q <= 7'h0f;
    end
    else
    begin
      meta_q <= {dip_sw, sda_in, scl_in, rx_hv, rx_ttl};
      sync_q <= meta_q;
    end
  end

  assign {dip_s, sda_s, scl_s, rx_hv_s, rx_ttl_s} = sync_q;

  // ----------------------------------------------------------------------
  // Serial receiver
  // ----------------------------------------------------------------------
  logic             hv_en_q;
  logic [BIT_W-1:0] bit_cyc_q;
  logic [BIT_W-1:0] rx_cnt_q;
  logic [3:0]       rx_bit_q;
  logic [7:0]       rx_sh_q;
  logic             rx_act_q;
  logic             u_valid_q;
  logic [7:0]       u_byte_q;
  logic             rx_line;

  // A 12 V transceiver cannot follow the faster rates, so it is muted.
  assign rx_line = rx_ttl_s & (rx_hv_s | !hv_en_q);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hv_en_q   <= 1'b1;
      bit_cyc_q <= '0;
    end
    else
    begin
      hv_en_q   <= baud_of(dip_s) <= HV_MAX_BAUD;
      bit_cyc_q <= bit_cycles(dip_s);
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_act_q  <= 1'b0;
      rx_cnt_q  <= '0;
      rx_bit_q  <= 4'h0;
      rx_sh_q   <= 8'h00;
      u_valid_q <= 1'b0;
      u_byte_q  <= 8'h00;
    end
    else
    begin
      u_valid_q <= 1'b0;
      if (!rx_act_q)
      begin
        if (!rx_line)
        begin
          rx_act_q <= 1'b1;
          rx_cnt_q <= bit_cyc_q >> 1;
          rx_bit_q <= 4'h0;
        end
      end
      else if (rx_cnt_q != '0)
      begin
        rx_cnt_q <= BIT_W'(rx_cnt_q - 1'b1);
      end
      else
      begin
        rx_cnt_q <= BIT_W'(bit_cyc_q - 1'b1);
        rx_bit_q <= 4'(rx_bit_q + 1'b1);
        if (rx_bit_q == 4'h0 && rx_line)
        begin
          rx_act_q <= 1'b0;
        end
        else if (rx_bit_q == 4'h9)
        begin
          rx_act_q  <= 1'b0;
          u_valid_q <= rx_line;
          u_byte_q  <= rx_sh_q;
        end
        else if (rx_bit_q != 4'h0)
        begin
          rx_sh_q <= {rx_line, rx_sh_q[7:1]};
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Two-wire slave receiver
  // ----------------------------------------------------------------------
  link_t      i_st_q;
  logic [3:0] i_bit_q;
  logic [7:0] i_sh_q;
  logic       scl_d1_q;
  logic       sda_d1_q;
  logic       sda_oe_q;
  logic       i_start;
  logic       i_stop;
  logic       i_rise;
  logic       i_fall;
  logic       i_byte_end;
  logic       i_push;
  logic       f_wr_ready;

  assign i_start    = scl_s && scl_d1_q && sda_d1_q && !sda_s;
  assign i_stop     = scl_s && scl_d1_q && !sda_d1_q && sda_s;
  assign i_rise     = scl_s && !scl_d1_q;
  assign i_fall     = !scl_s && scl_d1_q;
  assign i_byte_end = i_fall && i_bit_q == 4'h8;
  assign i_push     = i_byte_end && i_st_q == I_DATA && f_wr_ready;
  assign sda_out    = 1'b0;
  assign sda_oe     = sda_oe_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
      i_st_q   <= I_IDLE;
      i_bit_q  <= 4'h0;
      i_sh_q   <= 8'h00;
      sda_oe_q <= 1'b0;
    end
    else
    begin
      scl_d1_q <= scl_s;
      sda_d1_q <= sda_s;
      if (i_start)
      begin
        i_st_q   <= I_ADDR;
        i_bit_q  <= 4'h0;
        sda_oe_q <= 1'b0;
      end
      else if (i_stop)
      begin
        i_st_q   <= I_IDLE;
        sda_oe_q <= 1'b0;
      end
      else
      begin
        case (i_st_q)
          I_ADDR, I_DATA:
          begin
            if (i_rise && i_bit_q != 4'h8)
            begin
              i_sh_q  <= {i_sh_q[6:0], sda_s};
              i_bit_q <= 4'(i_bit_q + 1'b1);
            end
            else if (i_byte_end)
            begin
              i_bit_q <= 4'h0;
              // A full FIFO refuses the byte with a not-acknowledge.
              if (i_st_q == I_ADDR)
              begin
                sda_oe_q <= i_sh_q == {4'h0, dip_s, 1'b0};
                i_st_q   <= i_sh_q == {4'h0, dip_s, 1'b0} ? I_ACK : I_IDLE;
              end
              else
              begin
                sda_oe_q <= f_wr_ready;
                i_st_q   <= f_wr_ready ? I_ACK : I_IDLE;
              end
            end
          end
          I_ACK:
          begin
            if (i_fall)
            begin
              sda_oe_q <= 1'b0;
              i_st_q   <= I_DATA;
            end
          end
          default:
          begin
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Input FIFO and glyph store
  // ----------------------------------------------------------------------
  logic       f_wr_valid;
  logic [7:0] f_wr_data;
  logic       f_rd_valid;
  logic [7:0] f_rd_data;
  logic       pop;
  logic       glyph_we;
  logic [5:0] glyph_wa;
  logic       busy_q;

  // Two-wire bytes win a collision; the host never feeds both links.
  assign f_wr_valid = i_push || u_valid_q;
  assign f_wr_data  = i_push ? i_sh_q : u_byte_q;
  assign pop        = f_rd_valid && !busy_q;

  byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo
  (
    .clk      (clk),
    .reset_n  (reset_n),
    .wr_valid (f_wr_valid),
    .wr_ready (f_wr_ready),
    .wr_data  (f_wr_data),
    .rd_valid (f_rd_valid),
    .rd_ready (!busy_q),
    .rd_data  (f_rd_data)
  );

  glyph_ram u_glyph
  (
    .clk       (clk),
    .reset_n   (reset_n),
    .we        (glyph_we),
    .wr_addr   (glyph_wa),
    .wr_data   (f_rd_data),
    .rd_addr   (glyph_rd_addr),
    .rd_data_q (glyph_rd_data)
  );

  // ----------------------------------------------------------------------
  // Command parser
  // ----------------------------------------------------------------------
  parse_t     pst_q;
  logic [7:0] cmd_q;
  logic [3:0] arg_idx_q;
  logic [7:0] arg0_q;
  logic       disp_valid_q;
  op_t        disp_op_q;
  logic [7:0] disp_data_q;
  logic [4:0] col_q;
  logic [1:0] row_q;
  logic       cursor_q;
  logic       light_q;
  logic       glyph_ok;

  assign glyph_ok = arg0_q >= GLYPH_FIRST && arg0_q <= GLYPH_LAST;
  assign glyph_we = pop && pst_q == P_ARGS && cmd_q == CMD_GLYPH &&
                    arg_idx_q != 4'h0 && glyph_ok;
  assign glyph_wa = {arg0_q[2:0], 3'(arg_idx_q - 1'b1)};

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pst_q        <= P_IDLE;
      cmd_q        <= 8'h00;
      arg_idx_q    <= 4'h0;
      arg0_q       <= 8'h00;
      disp_valid_q <= 1'b0;
      disp_op_q    <= OP_NONE;
      disp_data_q  <= 8'h00;
      col_q        <= 5'h00;
      row_q        <= 2'h0;
      cursor_q     <= CURSOR_RESET;
      light_q      <= LIGHT_RESET;
    end
    else
    begin
      disp_valid_q <= 1'b0;
      if (pop)
      begin
        disp_data_q <= f_rd_data;
        case (pst_q)
          P_IDLE:
          begin
            if (f_rd_data == ESC_CODE)
            begin
              pst_q <= P_ESC;
            end
            else if (f_rd_data >= ROW_FIRST && f_rd_data <= ROW_LAST)
            begin
              disp_valid_q <= 1'b1;
              disp_op_q    <= OP_MOVE;
              col_q        <= 5'h00;
              row_q        <= 2'(f_rd_data - 1'b1);
            end
            else
            begin
              disp_valid_q <= 1'b1;
              disp_op_q    <= OP_CHAR;
              col_q        <= col_q == COLS - 1'b1 ? 5'h00 : 5'(col_q + 1'b1);
              row_q        <= col_q == COLS - 1'b1 ? 2'(row_q + 1'b1) : row_q;
            end
          end
          P_ESC:
          begin
            pst_q        <= P_IDLE;
            cmd_q        <= f_rd_data;
            arg_idx_q    <= 4'h0;
            disp_valid_q <= 1'b1;
            case (f_rd_data)
              CMD_CLEAR:
              begin
                disp_op_q <= OP_CLEAR;
                col_q     <= 5'h00;
                row_q     <= 2'h0;
              end
              CMD_CSR_ON, CMD_CSR_OFF:
              begin
                disp_op_q <= OP_CURSOR;
                cursor_q  <= f_rd_data == CMD_CSR_ON;
              end
              CMD_BL_ON, CMD_BL_OFF:
              begin
                disp_op_q <= OP_LIGHT;
                light_q   <= f_rd_data == CMD_BL_ON;
              end
              CMD_HOME:
              begin
                disp_op_q <= OP_MOVE;
                col_q     <= 5'h00;
                row_q     <= 2'h0;
              end
              CMD_LOCATE, CMD_GLYPH:
              begin
                disp_valid_q <= 1'b0;
                pst_q        <= P_ARGS;
              end
              default:
              begin
                disp_op_q <= OP_CHAR;
              end
            endcase
          end
          P_ARGS:
          begin
            arg_idx_q <= 4'(arg_idx_q + 1'b1);
            if (arg_idx_q == 4'h0)
            begin
              arg0_q <= f_rd_data;
            end
            if (cmd_q == CMD_LOCATE && arg_idx_q == LOCATE_ARGS - 1'b1)
            begin
              pst_q        <= P_IDLE;
              disp_valid_q <= 1'b1;
              disp_op_q    <= OP_MOVE;
              col_q        <= arg0_q[4:0];
              row_q        <= f_rd_data[1:0];
            end
            else if (cmd_q == CMD_GLYPH && arg_idx_q == GLYPH_ARGS - 1'b1)
            begin
              pst_q        <= P_IDLE;
              disp_valid_q <= glyph_ok;
              disp_op_q    <= OP_GLYPH;
              disp_data_q  <= arg0_q;
            end
          end
          default:
          begin
            pst_q <= P_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Execution timer
  // ----------------------------------------------------------------------
  logic [TIMER_W-1:0] timer_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      timer_q <= '0;
      busy_q  <= 1'b0;
    end
    else if (pop && pst_q == P_ESC && f_rd_data == CMD_CLEAR)
    begin
      timer_q <= TIMER_W'(CLEAR_WAIT - 1);
      busy_q  <= 1'b1;
    end
    else if (pop && pst_q == P_ARGS && cmd_q == CMD_LOCATE &&
             arg_idx_q == LOCATE_ARGS - 1'b1)
    begin
      timer_q <= TIMER_W'(LOCATE_CYCLES - 1);
      busy_q  <= 1'b1;
    end
    else if (timer_q != '0)
    begin
      timer_q <= TIMER_W'(timer_q - 1'b1);
    end
    else
    begin
      busy_q <= 1'b0;
    end
  end

  assign disp_valid   = disp_valid_q;
  assign disp_op      = disp_op_q;
  assign disp_data    = disp_data_q;
  assign disp_col     = col_q;
  assign disp_row     = row_q;
  assign cursor_on    = cursor_q;
  assign backlight_on = light_q;
  assign busy         = busy_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_clear_busy;
    @(posedge clk) disable iff (!reset_n)
    disp_valid_q && disp_op_q == OP_CLEAR |-> busy_q [*8];
  endproperty
  a_clear_busy: assert property (p_clear_busy)
    else $error("clear did not hold busy");

  property p_clear_home;
    @(posedge clk) disable iff (!reset_n)
    disp_valid_q && disp_op_q == OP_CLEAR |-> col_q == 5'h00 && row_q == 2'h0;
  endproperty
  a_clear_home: assert property (p_clear_home)
    else $error("clear did not home cursor");

  property p_row_move;
    @(posedge clk) disable iff (!reset_n)
    pop && pst_q == P_IDLE && f_rd_data >= ROW_FIRST &&
    f_rd_data <= ROW_LAST |=> disp_op_q == OP_MOVE && col_q == 5'h00 &&
    row_q == 2'($past(f_rd_data) - 1'b1);
  endproperty
  a_row_move: assert property (p_row_move)
    else $error("row move went to wrong place");

  property p_locate;
    @(posedge clk) disable iff (!reset_n)
    pop && pst_q == P_ARGS && cmd_q == CMD_LOCATE && arg_idx_q == 4'h1
    |=> disp_valid_q && busy_q && row_q == 2'($past(f_rd_data)) ##1 busy_q;
  endproperty
  a_locate: assert property (p_locate)
    else $error("locate did not move cursor");

  property p_glyph_range;
    @(posedge clk) disable iff (!reset_n)
    glyph_we |-> arg0_q[7:3] == GLYPH_FIRST[7:3] && cmd_q == CMD_GLYPH;
  endproperty
  a_glyph_range: assert property (p_glyph_range)
    else $error("glyph written outside codes 8 to 15");

  property p_char;
    @(posedge clk) disable iff (!reset_n)
    pop && pst_q == P_IDLE && f_rd_data > ROW_LAST && f_rd_data != ESC_CODE
    |=> disp_valid_q && disp_op_q == OP_CHAR && disp_data_q == $past(f_rd_data);
  endproperty
  a_char: assert property (p_char)
    else $error("plain byte not drawn");

  property p_cursor_off;
    @(posedge clk) disable iff (!reset_n)
    pop && pst_q == P_ESC && f_rd_data == CMD_CSR_OFF |=> !cursor_q;
  endproperty
  a_cursor_off: assert property (p_cursor_off)
    else $error("cursor stayed on");

  property p_esc;
    @(posedge clk) disable iff (!reset_n)
    pop && pst_q == P_IDLE && f_rd_data == ESC_CODE
    |=> pst_q == P_ESC && !disp_valid_q;
  endproperty
  a_esc: assert property (p_esc)
    else $error("escape did not open a command");

  property p_addr_nack;
    @(posedge clk) disable iff (!reset_n)
    i_st_q == I_ADDR && i_byte_end && !i_start && !i_stop &&
    i_sh_q != {4'h0, dip_s, 1'b0} |=> !sda_oe_q && i_st_q == I_IDLE;
  endproperty
  a_addr_nack: assert property (p_addr_nack)
    else $error("foreign address acknowledged");

  property p_hv_mute;
    @(posedge clk) disable iff (!reset_n)
    !hv_en_q |-> rx_line == rx_ttl_s;
  endproperty
  a_hv_mute: assert property (p_hv_mute)
    else $error("high-voltage input heard at fast rate");
endmodule

// *** char_lcd_command_interpreter_bench.sv ***
// Self-checking bench for the display command interpreter.
// Assumes lcd_host_model stands in for the host on both links.
`timescale 1ns/1ps
module char_lcd_command_interpreter_bench
  import lcd_pkg::*;
;
  localparam logic [17:0] ALL = 18'h3ffff;
  localparam logic [17:0] NO_DATA = 18'h3807f;
  localparam int NB = CLK_HZ / 115200;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [2:0]  dip_sw = 3'h7;
  logic [5:0]  glyph_rd_addr = 6'h0;
  logic        rx_ttl, rx_hv, scl, sda_low, sda_oe, sda_out, disp_valid, busy;
  op_t         disp_op;
  logic [7:0]  disp_data, glyph_rd_data;
  logic [4:0]  disp_col;
  logic [1:0]  disp_row;
  logic        cursor_on, backlight_on;
  logic [17:0] last;
  logic [1:0]  ack;
  int          error_cnt = 0, samples_checked = 0, seen = 0, busy_n = 0;

  always #25 clk = ~clk;
  always @(posedge clk)
  begin
    busy_n <= busy_n + int'(busy);
    if (disp_valid) seen <= seen + 1;
    if (disp_valid) last <= {disp_op, disp_data, disp_col, disp_row};
  end

  char_lcd_command_interpreter #(.CLEAR_WAIT(50)) dut (.clk, .reset_n,
    .rx_ttl, .rx_hv, .scl_in(scl), .sda_in(~sda_low & (sda_out | ~sda_oe)),
    .sda_out, .sda_oe, .dip_sw, .disp_valid, .disp_op, .disp_data,
    .disp_col, .disp_row, .cursor_on, .backlight_on, .busy,
    .glyph_rd_addr, .glyph_rd_data);
  lcd_host_model host (.clk, .sda_oe, .rx_ttl, .rx_hv, .scl, .sda_low);

  task automatic check(input logic [17:0] got, exp, m);
    samples_checked++;
    if (((got ^ exp) & m) !== 18'h0)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic send(input logic [7:0] b);
    host.uart(b, NB, 1'b0);
    repeat (20) @(posedge clk);
  endtask

  task automatic t_text();
    int n0;
    check(18'({cursor_on, backlight_on, busy}), 18'h6, ALL);
    send(8'h41);
    check(last, {OP_CHAR, 8'h41, 5'h1, 2'h0}, ALL);
    n0 = busy_n;
    send(ESC_CODE);
    send(CMD_LOCATE);
    send(8'h05);
    send(8'h02);
    repeat (2100) @(posedge clk);
    check(last, {OP_MOVE, 8'h0, 5'h5, 2'h2}, NO_DATA);
    check(18'((busy_n - n0) inside {[2000:2008]}), 18'h1, ALL);
    send(8'h5a);
    check(last, {OP_CHAR, 8'h5a, 5'h6, 2'h2}, ALL);
    send(8'h03);
    check(last, {OP_MOVE, 8'h0, 5'h0, 2'h2}, NO_DATA);
    n0 = busy_n;
    send(ESC_CODE);
    send(CMD_CLEAR);
    repeat (100) @(posedge clk);
    check(last, {OP_CLEAR, 15'h0}, 18'h3807f);
    check(18'((busy_n - n0) inside {[50:58]}), 18'h1, ALL);
  endtask

  task automatic t_modes();
    logic [31:0] c = {CMD_CSR_OFF, CMD_BL_OFF, CMD_CSR_ON, CMD_BL_ON};
    logic [7:0]  e = 8'h4b;
    for (int i = 0; i < 4; i++)
    begin
      send(ESC_CODE);
      send(c[31 - 8 * i -: 8]);
      check(18'({cursor_on, backlight_on}), 18'(e[7-2*i -: 2]), ALL);
    end
    send(ESC_CODE);
    send(CMD_HOME);
    check(last, {OP_MOVE, 8'h0, 5'h0, 2'h0}, NO_DATA);
  endtask

  task automatic t_glyph();
    send(ESC_CODE);
    send(CMD_GLYPH);
    send(8'h0f);
    for (int i = 0; i < 8; i++)
      send(8'ha0 + 8'(i));
    check(last, {OP_GLYPH, 8'h0f, 7'h0}, 18'h3ff80);
    glyph_rd_addr <= 6'h3d;
    repeat (3) @(posedge clk);
    check(18'(glyph_rd_data), 18'ha5, ALL);
  endtask

  task automatic t_links();
    int          n0;
    logic [7:0]  ad;
    logic [87:0] g = {ESC_CODE, CMD_GLYPH, 8'h20, 64'h0};
    ad = {4'h0, dip_sw, 1'b0};
    host.i2c(ad, 8'h51, ack);
    check(18'(ack), 18'h3, ALL);
    check(last, {OP_CHAR, 8'h51, 7'h0}, 18'h3ff80);
    n0 = seen;
    host.i2c(8'h0c, 8'h52, ack);
    host.uart(8'h58, NB, 1'b1);
    repeat (20) @(posedge clk);
    check(18'(ack), 18'h0, ALL);
    check(18'(seen - n0), 18'h0, ALL);
    // A glyph code outside the user range must load nothing and stay silent.
    for (int i = 0; i < 11; i++)
      host.i2c(ad, g[87 - 8 * i -: 8], ack);
    check(18'(seen - n0), 18'h0, ALL);
    host.i2c(ad, ESC_CODE, ack);
    host.i2c(ad, 8'h7a, ack);
    check(last, {OP_CHAR, 8'h7a, 7'h0}, 18'h3ff80);
    dip_sw <= 3'h5;
    repeat (8) @(posedge clk);
    host.uart(8'h59, CLK_HZ / 38400, 1'b1);
    repeat (20) @(posedge clk);
    check(last, {OP_CHAR, 8'h59, 7'h0}, 18'h3ff80);
  endtask

  task automatic tally_and_finish();
    if (error_cnt == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #5_000_000;
    error_cnt++;
    tally_and_finish();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_text();
    t_modes();
    t_glyph();
    t_links();
    tally_and_finish();
  end
endmodule

// *** glyph_ram.sv ***
// Pattern store for the eight user glyphs, eight rows each.
// Assumes one clock; read data appear one cycle after the address.
`timescale 1ns/1ps
module glyph_ram
  import lcd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       we,
  input  wire logic [5:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic [5:0] rd_addr,
  output logic      [7:0] rd_data_q
);
  logic [7:0] mem_q [GLYPH_WORDS];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_data_q <= 8'h00;
    end
    else
    begin
      rd_data_q <= mem_q[rd_addr];
    end
  end
endmodule

// *** lcd_host_model.sv ***
// Host controller model: serial frames and two-wire writes.
// Assumes calls start just after a rising clk edge; SDA is pulled up.
`timescale 1ns/1ps
module lcd_host_model
(
  input  wire logic clk,
  input  wire logic sda_oe,
  output logic      rx_ttl,
  output logic      rx_hv,
  output logic      scl,
  output logic      sda_low
);
  initial {rx_ttl, rx_hv, scl, sda_low} = 4'he;

  // One 8N1 frame, LSB first, nb clk cycles a bit.
  task automatic uart(input logic [7:0] b, input int nb, input logic hv);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      if (hv) rx_hv <= f[i];
      else rx_ttl <= f[i];
      repeat (nb) @(posedge clk);
    end
  endtask

  // One SCL period of 8 clk; a is the device's pull taken mid high.
  task automatic clk_bit(input logic v, output logic a);
    sda_low <= ~v;
    repeat (2) @(posedge clk);
    scl <= 1'b1;
    repeat (2) @(posedge clk);
    a = sda_oe;
    repeat (2) @(posedge clk);
    scl <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // Addressed write of one byte; the host drives the start condition at once, without waiting for idle.
  task automatic i2c(input logic [7:0] ad, input logic [7:0] d,
                     output logic [1:0] ack);
    logic [15:0] w;
    logic        a;
    w = {ad, d};
    sda_low <= 1'b1;
    repeat (4) @(posedge clk);
    scl <= 1'b0;
    repeat (2) @(posedge clk);
    for (int i = 15; i >= 0; i--)
    begin
      clk_bit(w[i], a);
      if (i % 8 == 0)
      begin
        clk_bit(1'b1, a);
        ack[i / 8] = a;
      end
    end
    sda_low <= 1'b1;
    repeat (2) @(posedge clk);
    scl <= 1'b1;
    repeat (2) @(posedge clk);
    sda_low <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule

// *** lcd_pkg.sv ***
// Constants, types and helper functions shared by the character display
// command interpreter and its storage modules.
// Assumes a single 20 MHz system clock for all timing figures.
package lcd_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ         = 20_000_000;
  localparam int CLEAR_TIME_MS  = 15;
  localparam int CLEAR_CYCLES   = CLK_HZ / 1000 * CLEAR_TIME_MS;
  localparam int LOCATE_TIME_US = 100;
  localparam int LOCATE_CYCLES  = CLK_HZ / 1_000_000 * LOCATE_TIME_US;
  localparam int TIMER_W        = 19;
  localparam int HV_MAX_BAUD    = 38400;
  localparam int BIT_W          = 14;

  // ----------------------------------------------------------------------
  // Byte codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] ESC_CODE    = 8'h1b;
  localparam logic [7:0] CMD_CLEAR   = 8'h43;
  localparam logic [7:0] CMD_CSR_ON  = 8'h53;
  localparam logic [7:0] CMD_CSR_OFF = 8'h73;
  localparam logic [7:0] CMD_BL_ON   = 8'h42;
  localparam logic [7:0] CMD_BL_OFF  = 8'h62;
  localparam logic [7:0] CMD_HOME    = 8'h48;
  localparam logic [7:0] CMD_LOCATE  = 8'h4c;
  localparam logic [7:0] CMD_GLYPH   = 8'h44;
  localparam logic [7:0] ROW_FIRST   = 8'h01;
  localparam logic [7:0] ROW_LAST    = 8'h04;
  localparam logic [7:0] GLYPH_FIRST = 8'h08;
  localparam logic [7:0] GLYPH_LAST  = 8'h0f;
  localparam logic [3:0] LOCATE_ARGS = 4'h2;
  localparam logic [3:0] GLYPH_ARGS  = 4'h9;

  // ----------------------------------------------------------------------
  // Screen and storage geometry, reset values
  // ----------------------------------------------------------------------
  localparam logic [4:0] COLS         = 5'h14;
  localparam int         FIFO_DEPTH   = 16;
  localparam int         FIFO_WIDTH   = 8;
  localparam int         GLYPH_WORDS  = 64;
  localparam logic       CURSOR_RESET = 1'b1;
  localparam logic       LIGHT_RESET  = 1'b1;

  typedef enum logic [2:0]
  {
    OP_NONE   = 3'b000,
    OP_CHAR   = 3'b001,
    OP_CLEAR  = 3'b010,
    OP_MOVE   = 3'b011,
    OP_CURSOR = 3'b100,
    OP_LIGHT  = 3'b101,
    OP_GLYPH  = 3'b110
  } op_t;

  function automatic int baud_of(input logic [2:0] sel);
    case (sel)
      3'h0:    return 2400;
      3'h1:    return 4800;
      3'h2:    return 9600;
      3'h3:    return 19200;
      3'h4:    return 28800;
      3'h5:    return 38400;
      3'h6:    return 57600;
      default: return 115200;
    endcase
  endfunction

  function automatic logic [BIT_W-1:0] bit_cycles(input logic [2:0] sel);
    return BIT_W'(CLK_HZ / baud_of(sel));
  endfunction

endpackage
